// [tfia_aggregator.sv]
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`include "tfia_params.svh"
module tfia_aggregator
  import tfia_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [31:0] threshold_bank0_flags,
  input  wire logic [31:0] threshold_bank1_flags,
  input  wire logic [31:0] threshold_bank2_flags,
  input  wire logic [31:0] threshold_bank3_flags,
  input  wire logic [31:0] stateFilterEvents,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [31:0] cpuIrqLines,
  output logic      [31:0] fabric_flag_outputs
);
  localparam int NB = `TFIA_BANKS;

  logic [31:0] flagMeta  [NB];
  logic [31:0] flagSync  [NB];
  logic [31:0] flagRaw   [NB];
  logic [31:0] filterMeta;
  logic [31:0] filterSync;
  logic [31:0] filterMask;
  logic [31:0] bankMask  [NB];
  logic [31:0] bankStatus[NB];
  logic [31:0] bankEnabled[NB];
  logic [NB-1:0] hitBank;
  tfia_reg_e   regSel;
  logic        filterHit;
  logic        writeStrobe;
  logic [31:0] next_irq;
  logic [31:0] next_rdata;
  logic [31:0] relAddr;
  logic [1:0]  bankIdx;

  assign flagRaw[0] = threshold_bank0_flags;
  assign flagRaw[1] = threshold_bank1_flags;
  assign flagRaw[2] = threshold_bank2_flags;
  assign flagRaw[3] = threshold_bank3_flags;

  // Flags come from the analog engine's domain, so two stages first
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NB; i++) begin
        flagMeta[i] <= '0;
        flagSync[i] <= '0;
      end
      filterMeta <= '0;
      filterSync <= '0;
    end else begin
      for (int i = 0; i < NB; i++) begin
        flagMeta[i] <= flagRaw[i];
        flagSync[i] <= flagMeta[i];
      end
      filterMeta <= stateFilterEvents;
      filterSync <= filterMeta;
    end
  end

  // Address decode; banks sit every three words from the bank 0 base
  assign writeStrobe = psel && penable && pwrite;
  assign relAddr     = paddr - `TFIA_BANK_BASE;
  assign filterHit   = (paddr == `TFIA_FILTER_MASK);

  always_comb begin
    regSel  = TFIA_REG_NONE;
    bankIdx = 2'h0;
    hitBank = '0;
    if (paddr[1:0] == 2'h0 && paddr >= `TFIA_BANK_BASE && paddr <= `TFIA_B3_CLEAR) begin
      bankIdx = 2'(relAddr / `TFIA_BANK_STRIDE);
      hitBank[bankIdx] = 1'h1;
      case (relAddr % `TFIA_BANK_STRIDE)
        `TFIA_OFS_MASK:   regSel = TFIA_REG_MASK;
        `TFIA_OFS_STATUS: regSel = TFIA_REG_STATUS;
        `TFIA_OFS_CLEAR:  regSel = TFIA_REG_CLEAR;
        default:          regSel = TFIA_REG_NONE;
      endcase
    end
  end

  genvar g;
  generate
    for (g = 0; g < NB; g++) begin : gBank
      tfia_bank_if bif ();
      assign bif.flags      = flagSync[g];
      assign bif.maskWrData = pwdata;
      assign bif.maskWr     = writeStrobe && hitBank[g] && regSel == TFIA_REG_MASK;
      assign bif.clearBits  = (writeStrobe && hitBank[g] && regSel == TFIA_REG_CLEAR)
                              ? pwdata : 32'h00000000;
      assign bankMask[g]    = bif.mask;
      assign bankStatus[g]  = bif.status;
      assign bankEnabled[g] = bif.enabled;
      tfia_flag_bank uBank (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .bus     (bif.bank)
      );
    end
  endgenerate

  // Filter events are taken as already qualified; only a mask is kept here
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      filterMask <= `TFIA_MASK_RESET;
    end else if (writeStrobe && filterHit) begin
      filterMask <= pwdata;
    end
  end

  always_comb begin
    next_irq = filterSync & filterMask;
    for (int i = 0; i < NB; i++) begin
      next_irq = next_irq | bankEnabled[i];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpuIrqLines         <= '0;
      fabric_flag_outputs <= '0;
    end else begin
      cpuIrqLines         <= next_irq;
      fabric_flag_outputs <= next_irq;
    end
  end

  always_comb begin
    next_rdata = 32'h00000000;
    if (filterHit) begin
      next_rdata = filterMask;
    end else begin
      case (regSel)
        TFIA_REG_MASK:   next_rdata = bankMask[bankIdx];
        TFIA_REG_STATUS: next_rdata = bankStatus[bankIdx];
        TFIA_REG_CLEAR:  next_rdata = 32'h00000000;
        default:         next_rdata = 32'h00000000;
      endcase
    end
  end

  // Zero-wait slave; unmapped addresses answer with an error
  assign pready  = 1'h1;
  assign pslverr = psel && penable && regSel == TFIA_REG_NONE && !filterHit;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_rdata;
    end
  end

  a_irq_or: assert property (@(posedge ref_clk) disable iff (!rst_n)
    1'h1 |=> cpuIrqLines == $past(bankEnabled[0] | bankEnabled[1] | bankEnabled[2]
                                  | bankEnabled[3] | (filterSync & filterMask)))
    else $error("interrupt is not OR of enabled bits");
  a_fabric_same: assert property (@(posedge ref_clk) disable iff (!rst_n)
    fabric_flag_outputs == cpuIrqLines)
    else $error("fabric bus differs from processor lines");
  a_mask_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (bankMask[0] | bankMask[1] | bankMask[2] | bankMask[3] | filterMask) == '0
      ##1 $stable(bankMask[0]) |-> cpuIrqLines == '0)
    else $error("masked status reached interrupt");
  a_clear_reads0: assert property (@(posedge ref_clk) disable iff (!rst_n)
    psel && penable && !pwrite && regSel == TFIA_REG_CLEAR |-> prdata == '0)
    else $error("clear register read non-zero");
  a_mask_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    writeStrobe && paddr == `TFIA_B0_MASK |=> bankMask[0] == $past(pwdata))
    else $error("bank 0 mask write lost");
  a_b1_status_rd: assert property (@(posedge ref_clk) disable iff (!rst_n)
    psel && !penable && !pwrite && paddr == `TFIA_B1_STATUS
      |=> prdata == $past(bankStatus[1]))
    else $error("bank 1 status read wrong");
endmodule : tfia_aggregator

// [tfia_params.svh]
`ifndef TFIA_PARAMS_SVH
`define TFIA_PARAMS_SVH

`define TFIA_BANKS          4
`define TFIA_WIDTH          32
`define TFIA_ADDR_W         32
`define TFIA_BANK_BASE      32'h40021224
`define TFIA_BANK_STRIDE    32'h0000000C
`define TFIA_OFS_MASK       32'h00000000
`define TFIA_OFS_STATUS     32'h00000004
`define TFIA_OFS_CLEAR      32'h00000008
`define TFIA_B0_MASK        32'h40021224
`define TFIA_B0_STATUS      32'h40021228
`define TFIA_B0_CLEAR       32'h4002122C
`define TFIA_B1_MASK        32'h40021230
`define TFIA_B1_STATUS      32'h40021234
`define TFIA_B1_CLEAR       32'h40021238
`define TFIA_B2_MASK        32'h4002123C
`define TFIA_B3_CLEAR       32'h40021250
`define TFIA_FILTER_MASK    32'h40021254
`define TFIA_MASK_RESET     32'h00000000
`define TFIA_STATUS_RESET   32'h00000000
`endif

// [tfia_pkg.sv]
package tfia_pkg;
  typedef logic [31:0] tfia_word_t;
  typedef enum logic [1:0] {
    TFIA_REG_MASK,
    TFIA_REG_STATUS,
    TFIA_REG_CLEAR,
    TFIA_REG_NONE
  } tfia_reg_e;
endpackage : tfia_pkg

// [tfia_bank_if.sv]
`timescale 1ns/1ps
interface tfia_bank_if;
  logic [31:0] flags;
  logic [31:0] maskWrData;
  logic        maskWr;
  logic [31:0] clearBits;
  logic [31:0] mask;
  logic [31:0] status;
  logic [31:0] enabled;
  modport ctrl (output flags, output maskWrData, output maskWr, output clearBits,
                input mask, input status, input enabled);
  modport bank (input flags, input maskWrData, input maskWr, input clearBits,
                output mask, output status, output enabled);
endinterface : tfia_bank_if

// [tfia_flag_bank.sv]
`timescale 1ns/1ps
`include "tfia_params.svh"
module tfia_flag_bank
  import tfia_pkg::*;
(
  input  wire logic  ref_clk,
  input  wire logic  rst_n,
  tfia_bank_if.bank  bus
);
  logic [31:0] flagPrev;
  logic [31:0] riseEvents;
  logic [31:0] next_status;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flagPrev <= '0;
    end else begin
      flagPrev <= bus.flags;
    end
  end

  assign riseEvents = bus.flags & ~flagPrev;

  // A set in the clearing cycle survives the clear
  assign next_status = (bus.status & ~bus.clearBits) | riseEvents;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus.status <= `TFIA_STATUS_RESET;
    end else begin
      bus.status <= next_status;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus.mask <= `TFIA_MASK_RESET;
    end else if (bus.maskWr) begin
      bus.mask <= bus.maskWrData;
    end
  end

  assign bus.enabled = bus.status & bus.mask;

  a_rise_sets: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (bus.flags & ~flagPrev) != '0 |=> (bus.status & $past(riseEvents)) == $past(riseEvents))
    else $error("rising flag did not set status");
  a_set_beats_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (riseEvents & bus.clearBits) != '0
      |=> (bus.status & $past(riseEvents & bus.clearBits)) == $past(riseEvents & bus.clearBits))
    else $error("clear beat a simultaneous set");
  a_clear_acts: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (bus.clearBits & ~riseEvents) != '0
      |=> (bus.status & $past(bus.clearBits & ~riseEvents)) == '0)
    else $error("clear did not reset status");
  a_zero_keeps: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ##1 ($past(bus.status) & ~$past(bus.clearBits) & ~bus.status) == '0)
    else $error("status bit dropped without clear");
endmodule : tfia_flag_bank

// [tfia_irq_sink.sv]
`timescale 1ns/1ps
module tfia_irq_sink
  import tfia_pkg::*;
(
  input  wire tfia_word_t irqLines,
  input  wire tfia_word_t fabricFlags,
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  output tfia_word_t      irqSeen,
  output tfia_word_t      fabricSeen
);
  // Level consumers sample once per clock, so a one-cycle pulse on
  // irqLines still shows in irqSeen for one cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqSeen    <= 32'h00000000;
      fabricSeen <= 32'h00000000;
    end else begin
      irqSeen    <= irqLines;
      fabricSeen <= fabricFlags;
    end
  end
endmodule : tfia_irq_sink

// [threshold_flag_irq_aggregator_bench.sv]
`timescale 1ns/1ps
`include "tfia_params.svh"
`define CHK(nm, ex, got) begin cmpCount++; if ((got) !== (ex)) begin errTotal++; \
  $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module threshold_flag_irq_aggregator_bench
  import tfia_pkg::*;
;
  logic       ref_clk;
  logic       rst_n;
  logic       psel;
  logic       penable;
  logic       pwrite;
  logic       pready;
  logic       pslverr;
  logic       slvErr;
  tfia_word_t flags0, flags1, flags2, flags3, filt;
  tfia_word_t paddr, pwdata, prdata, irq, fab, irqSeen, fabSeen, rd;
  tfia_word_t regs [6];
  int         errTotal;
  int         cmpCount;
  int         cycles;

  tfia_aggregator u_tfia_aggregator (
    .ref_clk(ref_clk), .rst_n(rst_n),
    .threshold_bank0_flags(flags0), .threshold_bank1_flags(flags1),
    .threshold_bank2_flags(flags2), .threshold_bank3_flags(flags3),
    .stateFilterEvents(filt), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpuIrqLines(irq), .fabric_flag_outputs(fab)
  );

  tfia_irq_sink u_tfia_irq_sink (
    .irqLines(irq), .fabricFlags(fab), .ref_clk(ref_clk), .rst_n(rst_n),
    .irqSeen(irqSeen), .fabricSeen(fabSeen)
  );

  initial begin
    ref_clk = 1'h0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic printVerdict();
    if (errTotal == 0 && cmpCount > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : printVerdict

  // Hang guard; the whole sequence needs about 120 cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errTotal++;
      printVerdict();
    end
  end

  // One APB transfer; request held until pready is seen high
  task automatic apbXfer(input logic wr, input tfia_word_t a, input tfia_word_t d);
    @(posedge ref_clk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    @(posedge ref_clk);
    while (pready !== 1'h1) @(posedge ref_clk);
    rd = prdata;
    slvErr = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask : apbXfer

  task automatic checkIrq(input tfia_word_t ex);
    repeat (6) @(posedge ref_clk);
    `CHK("irq lines", ex, irqSeen)
    `CHK("fabric flags", ex, fabSeen)
  endtask : checkIrq

  initial begin
    rst_n = 1'h0;
    {psel, penable, pwrite} = 3'h0;
    {paddr, pwdata, flags0, flags1, flags2, flags3, filt} = '0;
    regs = '{`TFIA_B0_MASK, `TFIA_B0_STATUS, `TFIA_B0_CLEAR,
             `TFIA_B1_MASK, `TFIA_B1_STATUS, `TFIA_B1_CLEAR};
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'h1;
    foreach (regs[i]) begin
      apbXfer(1'h0, regs[i], 32'h00000000);
      `CHK("reset value", 32'h00000000, rd)
    end
    apbXfer(1'h1, `TFIA_B0_MASK, 32'h00000011);
    apbXfer(1'h0, `TFIA_B0_MASK, 32'h00000000);
    `CHK("bank0 mask", 32'h00000011, rd)
    apbXfer(1'h1, `TFIA_B1_MASK, 32'h00000100);
    apbXfer(1'h0, `TFIA_B1_MASK, 32'h00000000);
    `CHK("bank1 mask", 32'h00000100, rd)
    apbXfer(1'h1, `TFIA_B1_CLEAR, 32'hFFFFFFFF);
    apbXfer(1'h0, `TFIA_B1_CLEAR, 32'h00000000);
    `CHK("clear readback", 32'h00000000, rd)
    apbXfer(1'h0, 32'h40021300, 32'h00000000);
    `CHK("unmapped error", 1'h1, slvErr)
    `CHK("unmapped data", 32'h00000000, rd)
    flags0 <= 32'h00000003;
    flags1 <= 32'h00000100;
    checkIrq(32'h00000101);
    apbXfer(1'h0, `TFIA_B0_STATUS, 32'h00000000);
    `CHK("bank0 status", 32'h00000003, rd)
    apbXfer(1'h0, `TFIA_B1_STATUS, 32'h00000000);
    `CHK("bank1 status", 32'h00000100, rd)
    // Flag bit 0 stays high: only an edge may set the bit again
    apbXfer(1'h1, `TFIA_B0_CLEAR, 32'h00000001);
    apbXfer(1'h0, `TFIA_B0_STATUS, 32'h00000000);
    `CHK("clear one bit", 32'h00000002, rd)
    checkIrq(32'h00000100);
    apbXfer(1'h1, `TFIA_B0_MASK, 32'h00000013);
    checkIrq(32'h00000102);
    // Bit 4 sets on the same edge that its clear write lands
    flags0 <= 32'h00000013;
    apbXfer(1'h1, `TFIA_B0_CLEAR, 32'h00000010);
    apbXfer(1'h0, `TFIA_B0_STATUS, 32'h00000000);
    `CHK("set beats clear", 32'h00000012, rd)
    checkIrq(32'h00000112);
    apbXfer(1'h1, `TFIA_B2_MASK, 32'h00000002);
    apbXfer(1'h1, `TFIA_B3_CLEAR - 32'h00000008, 32'h80000000);
    apbXfer(1'h1, `TFIA_FILTER_MASK, 32'h40000000);
    flags2 <= 32'h00000002;
    flags3 <= 32'h80000000;
    filt   <= 32'h40000000;
    checkIrq(32'hC0000112);
    filt <= 32'h00000000;
    checkIrq(32'h80000112);
    printVerdict();
  end
endmodule : threshold_flag_irq_aggregator_bench
